// File: verilog/tcwp_map.svh
`ifndef TCWP_MAP_SVH
`define TCWP_MAP_SVH
`define TCWP_FRAME_BITS 16
`define TCWP_CODE_MSB 15
`define TCWP_CODE_LSB 14
`define TCWP_DIR_BIT 13
`define TCWP_IDX_MSB 12
`define TCWP_IDX_LSB 8
`define TCWP_DATA_MSB 7
`define TCWP_DATA_LSB 0
`define TCWP_CHIP_CODE 2'h2
`define TCWP_DIR_WRITE 1'h1
`define TCWP_NUM_REGS 32
`define TCWP_REG_RESET 8'h00
`define TCWP_MCLK_MHZ 200
`define TCWP_SCLK_MAX_MHZ 5
`define TCWP_SCLK_MIN_CYCLES ((`TCWP_MCLK_MHZ) / (`TCWP_SCLK_MAX_MHZ))
`endif

// File: verilog/tcwp_pkg.sv
package tcwp_pkg;
  typedef enum logic [1:0] {
    TCWP_IDLE,
    TCWP_SHIFT,
    TCWP_DONE
  } tcwp_state_type;
  typedef logic [7:0] tcwp_byte_type;
endpackage : tcwp_pkg

// File: verilog/tcwp_sync.sv
`timescale 1ns/1ps
module tcwp_sync #(
  // Level shown during reset; set it to the pin's idle level.
  parameter logic RESET_LEVEL = 1'h0
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Asynchronous input and its synchronised copy.
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : tcwp_sync

// File: verilog/tcwp_port.sv
`timescale 1ns/1ps
`include "tcwp_map.svh"
// Overview of operation
// - Strap low selects three-wire, high selects I2C
// - Frame: chip code, direction, index, payload
// - Write only; direction bit must be one
// - Data sampled on serial clock rising edge
// - Latch and write on sixteenth rising edge
// - Power-down low returns registers to defaults
module tcwp_port
  import tcwp_pkg::*;
#(
  parameter int NUM_REGS = `TCWP_NUM_REGS
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Straps and power-down pin.
  input wire logic i2c_select,
  input wire logic power_down_n,
  // Three-wire serial pins.
  input wire logic port_select_n,
  input wire logic control_serial_clock,
  input wire logic control_serial_in,
  // Register file view.
  output logic [NUM_REGS*8-1:0] reg_file,
  output logic three_wire_mode,
  output logic write_strobe,
  output logic [4:0] frame_reg_index,
  output logic [7:0] frame_payload
);
  // ********************************************************
  // Checks and input synchronisers.
  // ********************************************************
  // The 5-bit frame index cannot reach more than 32 registers.
  if (NUM_REGS < 1 || NUM_REGS > `TCWP_NUM_REGS) begin : g_bad_num_regs
    $error("NUM_REGS must lie between 1 and 32.");
  end
  logic sel_n_s;
  logic sclk_s;
  logic sdi_s;
  logic pdn_s;
  logic strap_s;
  // Select and serial clock idle high, so their synchronisers reset high: a
  // low reset level would show a false select fall and clock rise after reset.
  tcwp_sync #(.RESET_LEVEL(1'h1)) u_sync_sel (.mclk(mclk), .rst(rst),
    .async_in(port_select_n), .sync_out(sel_n_s));
  tcwp_sync #(.RESET_LEVEL(1'h1)) u_sync_clk (.mclk(mclk), .rst(rst),
    .async_in(control_serial_clock), .sync_out(sclk_s));
  tcwp_sync u_sync_sdi (.mclk(mclk), .rst(rst), .async_in(control_serial_in), .sync_out(sdi_s));
  tcwp_sync u_sync_pdn (.mclk(mclk), .rst(rst), .async_in(power_down_n), .sync_out(pdn_s));
  tcwp_sync u_sync_i2c (.mclk(mclk), .rst(rst), .async_in(i2c_select), .sync_out(strap_s));
  // ********************************************************
  // Edge detection and frame shifting.
  // ********************************************************
  logic sclk_d;
  logic sel_n_d;
  logic [`TCWP_FRAME_BITS-1:0] shreg;
  logic [4:0] bitcnt;
  tcwp_state_type state;
  tcwp_state_type next_state;
  // Field extraction shared by the write path.
  function automatic logic [4:0] index_of(input logic [`TCWP_FRAME_BITS-1:0] f);
    return f[`TCWP_IDX_MSB:`TCWP_IDX_LSB];
  endfunction : index_of
  function automatic logic [7:0] payload_of(input logic [`TCWP_FRAME_BITS-1:0] f);
    return f[`TCWP_DATA_MSB:`TCWP_DATA_LSB];
  endfunction : payload_of
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sel_fall = ~sel_n_s & sel_n_d;
  wire [`TCWP_FRAME_BITS-1:0] next_shreg = {shreg[`TCWP_FRAME_BITS-2:0], sdi_s};
  wire last_bit = (bitcnt == 5'(`TCWP_FRAME_BITS - 1)) && sclk_rise;
  wire frame_ok = (next_shreg[`TCWP_CODE_MSB:`TCWP_CODE_LSB] == `TCWP_CHIP_CODE)
    && (next_shreg[`TCWP_DIR_BIT] == `TCWP_DIR_WRITE);
  wire next_write = ~strap_s && pdn_s && (state == TCWP_SHIFT) && ~sel_n_s
    && last_bit && frame_ok;
  always_comb begin
    next_state = state;
    case (state)
      TCWP_IDLE: begin
        if (sel_fall && ~strap_s) begin
          next_state = TCWP_SHIFT;
        end
      end
      TCWP_SHIFT: begin
        if (sel_n_s || strap_s) begin
          next_state = TCWP_IDLE;
        end else if (last_bit) begin
          next_state = TCWP_DONE;
        end
      end
      TCWP_DONE: begin
        if (sel_n_s) begin
          next_state = TCWP_IDLE;
        end
      end
      default: begin
        next_state = TCWP_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_d <= 1'h1;
      sel_n_d <= 1'h1;
      state <= TCWP_IDLE;
      shreg <= '0;
      bitcnt <= '0;
    end else begin
      sclk_d <= sclk_s;
      sel_n_d <= sel_n_s;
      state <= next_state;
      if (state != TCWP_SHIFT) begin
        bitcnt <= '0;
      end else if (sclk_rise) begin
        shreg <= next_shreg;
        bitcnt <= bitcnt + 5'h01;
      end
    end
  end
  // ********************************************************
  // Register file.
  // ********************************************************
  logic [7:0] regs [NUM_REGS];
  wire [4:0] wr_idx = index_of(next_shreg);
  wire [7:0] wr_data = payload_of(next_shreg);
  always_ff @(posedge mclk) begin
    if (rst || ~pdn_s) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= `TCWP_REG_RESET;
      end
      write_strobe <= 1'b0;
      frame_reg_index <= 5'h00;
      frame_payload <= 8'h00;
    end else begin
      write_strobe <= next_write;
      if (next_write) begin
        frame_reg_index <= wr_idx;
        frame_payload <= wr_data;
        // An index past the last register pulses the strobe but stores nothing.
        if (32'(wr_idx) < NUM_REGS) begin
          regs[wr_idx] <= wr_data;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_file[i*8 +: 8] = regs[i];
    end
  end
  assign three_wire_mode = ~strap_s;
  // ********************************************************
  // Assertions.
  // ********************************************************
  property p_mode;
    @(posedge mclk) disable iff (rst) strap_s |-> ##1 !write_strobe;
  endproperty
  a_mode: assert property (p_mode) else $error("Write in I2C mode.");
  property p_code;
    @(posedge mclk) disable iff (rst)
      write_strobe |-> $past(next_shreg[`TCWP_CODE_MSB:`TCWP_CODE_LSB]) == `TCWP_CHIP_CODE;
  endproperty
  a_code: assert property (p_code) else $error("Bad chip code written.");
  property p_dir;
    @(posedge mclk) disable iff (rst)
      write_strobe |-> $past(next_shreg[`TCWP_DIR_BIT]) == `TCWP_DIR_WRITE;
  endproperty
  a_dir: assert property (p_dir) else $error("Read frame written.");
  property p_sixteen;
    @(posedge mclk) disable iff (rst)
      write_strobe |-> $past(bitcnt) == 5'(`TCWP_FRAME_BITS - 1);
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("Write not on edge 16.");
  property p_edge;
    @(posedge mclk) disable iff (rst) write_strobe |-> $past(sclk_rise);
  endproperty
  a_edge: assert property (p_edge) else $error("Write not on rising edge.");
  property p_payload;
    @(posedge mclk) disable iff (rst || !pdn_s)
      write_strobe && (32'(frame_reg_index) < NUM_REGS)
        |-> regs[frame_reg_index] == frame_payload;
  endproperty
  a_payload: assert property (p_payload) else $error("Register not updated.");
  property p_pdn;
    @(posedge mclk) disable iff (rst)
      !pdn_s |=> regs[0] == `TCWP_REG_RESET && !write_strobe;
  endproperty
  a_pdn: assert property (p_pdn) else $error("Power-down did not clear.");
  property p_short;
    @(posedge mclk) disable iff (rst)
      state == TCWP_SHIFT && sel_n_s |=> state == TCWP_IDLE ##1 !write_strobe;
  endproperty
  a_short: assert property (p_short) else $error("Short frame kept.");
  property p_frame;
    @(posedge mclk) disable iff (rst) write_strobe |-> !$past(state == TCWP_IDLE);
  endproperty
  a_frame: assert property (p_frame) else $error("Write outside frame.");
  property p_pulse;
    @(posedge mclk) disable iff (rst) write_strobe |=> !write_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Strobe held past one cycle.");
  property p_hold;
    @(posedge mclk) disable iff (rst || !pdn_s)
      !next_write |=> $stable(frame_reg_index) && $stable(frame_payload);
  endproperty
  a_hold: assert property (p_hold) else $error("Latched frame changed.");
  property p_count;
    @(posedge mclk) disable iff (rst) bitcnt <= 5'(`TCWP_FRAME_BITS);
  endproperty
  a_count: assert property (p_count) else $error("Bit counter ran past frame.");
  property p_rearm;
    @(posedge mclk) disable iff (rst) state != TCWP_SHIFT |=> bitcnt == 5'h00;
  endproperty
  a_rearm: assert property (p_rearm) else $error("Counter not cleared.");
  property p_strap;
    @(posedge mclk) disable iff (rst) strap_s && state == TCWP_IDLE |=> state == TCWP_IDLE;
  endproperty
  a_strap: assert property (p_strap) else $error("Frame started in I2C mode.");
endmodule : tcwp_port

// File: sim/tcwp_host.sv
`timescale 1ns/1ps
module tcwp_host (
  // Serial control pins.
  input wire logic mclk,
  output logic port_select_n,
  output logic control_serial_clock,
  output logic control_serial_in
);
  // ********
  // Frame sender; the clock idles high.
  // ********
  // Half period of the link clock in ns; the default presses the samplers.
  int half_ns = 24;
  initial begin
    port_select_n = 1'h1;
    control_serial_clock = 1'h1;
    control_serial_in = 1'h0;
  end
  task automatic send(input logic [15:0] frame, input int nbits);
    @(negedge mclk);
    port_select_n = 1'h0;
    for (int i = 15; i > 15 - nbits; i--) begin
      #(half_ns);
      control_serial_clock = 1'h0;
      control_serial_in = frame[i];
      #(half_ns);
      control_serial_clock = 1'h1;
    end
    #(half_ns);
    port_select_n = 1'h1;
    control_serial_in = ~control_serial_in;
  endtask : send
endmodule : tcwp_host

// File: sim/tb_tcwp_port.sv
`timescale 1ns/1ps
module tb_tcwp_port;
  logic mclk, rst, i2c_select, power_down_n;
  wire logic port_select_n, control_serial_clock, control_serial_in;
  logic [255:0] reg_file, exp_file;
  logic three_wire_mode, write_strobe;
  logic [4:0] frame_reg_index;
  logic [7:0] frame_payload;
  logic [12:0] exp_q[$];
  logic [15:0] seed, t;
  int errors, check_count;
  tcwp_port u_dut (.mclk(mclk), .rst(rst), .i2c_select(i2c_select),
    .power_down_n(power_down_n), .port_select_n(port_select_n),
    .control_serial_clock(control_serial_clock), .control_serial_in(control_serial_in),
    .reg_file(reg_file), .three_wire_mode(three_wire_mode), .write_strobe(write_strobe),
    .frame_reg_index(frame_reg_index), .frame_payload(frame_payload));
  tcwp_host u_host (.mclk(mclk), .port_select_n(port_select_n),
    .control_serial_clock(control_serial_clock), .control_serial_in(control_serial_in));
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input string name, input logic [255:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [15:0] rnd;
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction : rnd
  task automatic frame(input logic [15:0] f, input int n);
    if (n == 16 && f[15:13] == 3'h5 && !i2c_select && power_down_n) begin
      exp_q.push_back(f[12:0]);
      exp_file[f[12:8]*8 +: 8] = f[7:0];
    end
    u_host.send(f, n);
    repeat (10) @(negedge mclk);
    check("reg_file", reg_file, exp_file);
  endtask : frame
  // ********
  // Result watcher.
  // ********
  always @(negedge mclk) if (write_strobe === 1'h1) begin
    if (exp_q.size() == 0) check("unexpected write", 1, 0);
    else check("index_payload", {frame_reg_index, frame_payload}, exp_q.pop_front());
  end
  initial begin
    #300us;
    errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'h1;
    i2c_select = 1'h0;
    power_down_n = 1'h1;
    errors = 0;
    check_count = 0;
    seed = 16'hECA8;
    exp_file = '0;
    repeat (10) @(negedge mclk);
    rst = 1'h0;
    repeat (6) @(negedge mclk);
    check("three_wire_mode", three_wire_mode, 1);
    for (int i = 0; i < 8; i++) begin
      t = rnd();
      frame({3'h5, t[12:0]}, 16);
    end
    u_host.half_ns = 100;
    t = rnd();
    frame({3'h5, t[12:0]}, 16);
    u_host.half_ns = 24;
    $display("test writes done");
    for (int c = 0; c < 8; c++) begin
      t = rnd();
      frame({c[2:0], t[12:0]}, 16);
    end
    frame({3'h5, t[12:0]}, 15);
    $display("test discards done");
    i2c_select = 1'h1;
    repeat (8) @(negedge mclk);
    check("three_wire_mode", three_wire_mode, 0);
    frame({3'h5, ~t[12:0]}, 16);
    i2c_select = 1'h0;
    repeat (8) @(negedge mclk);
    $display("test strap done");
    power_down_n = 1'h0;
    exp_file = '0;
    repeat (8) @(negedge mclk);
    check("reg_file", reg_file, exp_file);
    t = rnd();
    frame({3'h5, t[12:0]}, 16);
    power_down_n = 1'h1;
    repeat (8) @(negedge mclk);
    t = rnd();
    frame({3'h5, t[12:0]}, 16);
    check("pending", exp_q.size(), 0);
    $display("test power down done");
    report_and_stop();
  end
endmodule : tb_tcwp_port
